// ==== rcd_regs.vh ====
// Constants for the registered command/address buffer: control word bits,
// buffered word layout, class codes and error timing.
// Assumes inclusion by bare name from the buffer's design files.
`ifndef RCD_REGS_VH
`define RCD_REGS_VH

// Control word zero bit positions.
`define RCD_CW0_W          5
`define RCD_CW0_DIS_A      0
`define RCD_CW0_DIS_B      1
`define RCD_CW0_LAT_3T     3
`define RCD_CW0_FLOAT      4

// Buffered word layout, one word per input clock cycle.
`define RCD_WORD_W         32
`define RCD_FIFO_DEPTH     16
`define RCD_FIFO_AW        4
`define RCD_F_CLS          30
`define RCD_F_CKE          28
`define RCD_F_ODT          26
`define RCD_F_CS           22
`define RCD_F_ADDR         6
`define RCD_F_BA           3
`define RCD_F_RAS          2
`define RCD_F_CAS          1
`define RCD_F_WE           0

// Class of a captured cycle.
`define RCD_CLS_HOLD       2'h0
`define RCD_CLS_FWD        2'h1
`define RCD_CLS_FLOAT      2'h2

// Reset values.
`define RCD_RST_Q          16'h0000
`define RCD_CS_IDLE        4'hF
`define RCD_CW0_NONE       5'h00

// Error output: asserted after this many edges, held this many cycles.
`define RCD_ERR_DELAY      3
`define RCD_ERR_HOLD       2

`endif

// ==== rcd_fifo.v ====
// Synchronous FIFO holding captured command/address words.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module rcd_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             i_clk,
   input  wire             i_rst_b,
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   output wire             o_out_valid,
   input  wire             i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);

   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr;
   reg  [AW-1:0]    rd_ptr;
   reg  [AW:0]      count;
   wire             push;
   wire             pop;

   assign o_in_ready  = (count != DEPTH[AW:0]);
   assign o_out_valid = (count != {(AW+1){1'b0}});
   assign o_out_data  = mem[rd_ptr];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   always @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push && !pop) begin
            count <= count + {{AW{1'b0}}, 1'b1};
         end else if (pop && !push) begin
            count <= count - {{AW{1'b0}}, 1'b1};
         end
      end
   end

endmodule // rcd_fifo

`default_nettype wire

// ==== rcd_main.v ====
// Registered command/address buffer with chip-select gating, two output
// copies and parity checking of the gated inputs.
// Assumes inputs synchronous to I_REF_CLK; straps are static after reset.
//
// What this block does
// - Clock-enable and termination always registered and forwarded.
// - Gated inputs forwarded only with chip select low.
// - Both selects low: gated outputs keep values.
// - Two-select mode ignores selects two and three.
// - Outputs change after edge, after configured latency.
// - Copies A and B enabled separately by control word.
// - Parity bit sampled one cycle after data.
// - Parity failure pulls active-low error output low.
// - Error asserts three cycles later, lasts two.
// - Reset clears state and floats all outputs.
// - After reset outputs driven low, error high.
// - Ballout strap selects front or back pin order.
// - Flip strap high turns off input termination.
// - Low strap enables four-select mode, default two.
// - Sixteen address, three bank, three command bits.
// - No select: hold, or float unless three-cycle timing.
`include "rcd_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module rcd_main (
   input  wire                   I_REF_CLK,
   input  wire                   I_RST_B,
   input  wire [1:0]             I_DRAM_CLK_EN_IN,
   input  wire [1:0]             I_TERMINATION_CTRL_IN,
   input  wire [15:0]            I_ADDR_IN,
   input  wire [2:0]             I_BANK_ADDR_IN,
   input  wire                   I_ROW_STROBE_IN,
   input  wire                   I_COLUMN_STROBE_IN,
   input  wire                   I_WRITE_EN_IN,
   input  wire                   I_CHIP_SEL_IN_0,
   input  wire                   I_CHIP_SEL_IN_1,
   input  wire                   I_CHIP_SEL_IN_2,
   input  wire                   I_CHIP_SEL_IN_3,
   input  wire                   I_PARITY_BIT_IN,
   input  wire                   I_BALLOUT_FLIP,
   input  wire                   I_FOUR_SELECT_STRAP_N,
   input  wire [`RCD_CW0_W-1:0]  I_CONTROL_WORD_ZERO,
   input  wire                   I_DRAIN_EN,
   output wire [15:0]            O_ADDR_OUT_A,
   output wire [2:0]             O_BANK_ADDR_OUT_A,
   output wire                   O_ROW_STROBE_OUT_A,
   output wire                   O_COLUMN_STROBE_OUT_A,
   output wire                   O_WRITE_EN_OUT_A,
   output wire [1:0]             O_CHIP_SEL_OUT_A,
   output wire [1:0]             O_DRAM_CLK_EN_OUT_A,
   output wire [1:0]             O_TERMINATION_CTRL_OUT_A,
   output wire                   O_CMD_ADDR_OE_A,
   output wire                   O_CTRL_OE_A,
   output wire [15:0]            O_ADDR_OUT_B,
   output wire [2:0]             O_BANK_ADDR_OUT_B,
   output wire                   O_ROW_STROBE_OUT_B,
   output wire                   O_COLUMN_STROBE_OUT_B,
   output wire                   O_WRITE_EN_OUT_B,
   output wire [1:0]             O_CHIP_SEL_OUT_B,
   output wire [1:0]             O_DRAM_CLK_EN_OUT_B,
   output wire [1:0]             O_TERMINATION_CTRL_OUT_B,
   output wire                   O_CMD_ADDR_OE_B,
   output wire                   O_CTRL_OE_B,
   output reg                    O_PARITY_FAIL_N,
   output reg                    O_PARITY_FAIL_OE,
   output reg                    O_INPUT_LINE_TERMINATION,
   output reg                    O_FOUR_SELECT_MODE,
   output reg                    O_ACCEPT
);

   // Undo the mirrored pin order: pairs 3/4, 5/6, 7/8 and banks 0/1.
   function [18:0] unmirror;
      input [15:0] a;
      input [2:0]  ba;
      input        flip;
      begin
         if (flip) begin
            unmirror = {ba[2], ba[0], ba[1], a[15:9], a[7], a[8], a[5],
                        a[6], a[3], a[4], a[2:0]};
         end else begin
            unmirror = {ba, a};
         end
      end
   endfunction

   wire [3:0]             cs_raw;
   wire [3:0]             cs_en;
   wire [18:0]            addr_fix;
   wire                   any_lo;
   wire                   pair_lo;
   wire                   gated_par;
   reg  [1:0]             cls;
   wire [`RCD_WORD_W-1:0] in_word;
   wire                   fifo_in_ready;
   wire                   fifo_out_valid;
   wire [`RCD_WORD_W-1:0] fifo_out_data;
   wire                   rd_fire;
   wire                   use_valid;
   wire [`RCD_WORD_W-1:0] use_word;
   wire                   lat_3t;
   wire [1:0]             use_cls;

   reg                    strap_taken;
   reg                    ext_valid;
   reg  [`RCD_WORD_W-1:0] ext_word;
   reg                    par_chk;
   reg                    par_sum;
   reg                    err1;
   reg                    err2;
   reg                    err3;

   assign cs_raw = {I_CHIP_SEL_IN_3, I_CHIP_SEL_IN_2,
                    I_CHIP_SEL_IN_1, I_CHIP_SEL_IN_0};
   // Unused selects read as idle so a floating pin cannot gate anything.
   assign cs_en  = O_FOUR_SELECT_MODE ? cs_raw
                                      : {2'b11, cs_raw[1:0]};
   assign any_lo  = (cs_en != `RCD_CS_IDLE);
   assign pair_lo = (cs_en[1:0] == 2'b00) | (cs_en[3:2] == 2'b00);
   assign addr_fix = unmirror(I_ADDR_IN, I_BANK_ADDR_IN,
                              I_BALLOUT_FLIP);
   assign gated_par = ^{I_ADDR_IN, I_BANK_ADDR_IN, I_ROW_STROBE_IN,
                        I_COLUMN_STROBE_IN, I_WRITE_EN_IN};
   assign lat_3t = I_CONTROL_WORD_ZERO[`RCD_CW0_LAT_3T];

   // Classify the captured cycle. A pair of lows is a control word access
   // or an illegal pattern; both leave the gated outputs as they were.
   always @* begin
      if (any_lo && !pair_lo) begin
         cls = `RCD_CLS_FWD;
      end else if (any_lo) begin
         cls = `RCD_CLS_HOLD;
      end else if (I_CONTROL_WORD_ZERO[`RCD_CW0_FLOAT] && !lat_3t) begin
         cls = `RCD_CLS_FLOAT;
      end else begin
         cls = `RCD_CLS_HOLD;
      end
   end

   assign in_word = {cls, I_DRAM_CLK_EN_IN, I_TERMINATION_CTRL_IN,
                     (cls == `RCD_CLS_FWD) ? cs_en : `RCD_CS_IDLE,
                     addr_fix[15:0], addr_fix[18:16], I_ROW_STROBE_IN,
                     I_COLUMN_STROBE_IN, I_WRITE_EN_IN};

   // Every cycle after the strap edge is buffered while the FIFO has room, so clock-enable and termination keep flowing.
   rcd_fifo #(
      .WIDTH (`RCD_WORD_W),
      .DEPTH (`RCD_FIFO_DEPTH),
      .AW    (`RCD_FIFO_AW)
   ) u_fifo (
      .i_clk       (I_REF_CLK),
      .i_rst_b     (I_RST_B),
      .i_in_valid  (strap_taken),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (in_word),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (I_DRAIN_EN),
      .o_out_data  (fifo_out_data)
   );

   assign rd_fire   = fifo_out_valid & I_DRAIN_EN;
   // Three-cycle timing adds one register stage in front of the outputs.
   assign use_valid = lat_3t ? ext_valid : rd_fire;
   assign use_word  = lat_3t ? ext_word  : fifo_out_data;
   assign use_cls   = use_word[`RCD_F_CLS+1:`RCD_F_CLS];

   // The four-select strap is caught once on the first edge after reset release; the flip strap is followed every cycle.
   always @(posedge I_REF_CLK) begin
      if (!I_RST_B) begin
         strap_taken              <= 1'b0;
         O_FOUR_SELECT_MODE       <= 1'b0;
         O_INPUT_LINE_TERMINATION <= 1'b0;
         O_ACCEPT                 <= 1'b0;
         ext_valid                <= 1'b0;
         ext_word                 <= {`RCD_WORD_W{1'b0}};
      end else begin
         if (!strap_taken) begin
            strap_taken        <= 1'b1;
            O_FOUR_SELECT_MODE <= ~I_FOUR_SELECT_STRAP_N;
         end
         O_INPUT_LINE_TERMINATION <= ~I_BALLOUT_FLIP;
         O_ACCEPT                 <= fifo_in_ready;
         ext_valid                <= rd_fire;
         ext_word                 <= fifo_out_data;
      end
   end

   // Parity follows the data by one edge, so the checked sum waits a cycle.
   always @(posedge I_REF_CLK) begin
      if (!I_RST_B) begin
         par_chk          <= 1'b0;
         par_sum          <= 1'b0;
         err1             <= 1'b0;
         err2             <= 1'b0;
         err3             <= 1'b0;
         O_PARITY_FAIL_N  <= 1'b1;
         O_PARITY_FAIL_OE <= 1'b0;
      end else begin
         par_chk          <= strap_taken & any_lo;
         par_sum          <= gated_par;
         err1             <= par_chk & (par_sum ^ I_PARITY_BIT_IN);
         err2             <= err1;
         err3             <= err2;
         O_PARITY_FAIL_N  <= ~(err2 | err3);
         O_PARITY_FAIL_OE <= err2 | err3;
      end
   end

   // Per-copy output registers.
   reg  [15:0] q_addr  [0:1];
   reg  [2:0]  q_ba    [0:1];
   reg         q_ras   [0:1];
   reg         q_cas   [0:1];
   reg         q_we    [0:1];
   reg  [1:0]  q_cs    [0:1];
   reg  [1:0]  q_cke   [0:1];
   reg  [1:0]  q_odt   [0:1];
   reg         q_ca_oe [0:1];
   reg         q_ct_oe [0:1];

   genvar k;
   generate
      for (k = 0; k < 2; k = k + 1) begin : g_copy
         wire dis;
         wire [1:0] cs_slice;

         assign dis = I_CONTROL_WORD_ZERO[`RCD_CW0_DIS_A + k];
         // Copy B carries selects two and three in four-select mode.
         assign cs_slice = (O_FOUR_SELECT_MODE && k == 1)
                         ? use_word[`RCD_F_CS+3:`RCD_F_CS+2]
                         : use_word[`RCD_F_CS+1:`RCD_F_CS];

         always @(posedge I_REF_CLK) begin
            if (!I_RST_B) begin
               q_addr[k]  <= `RCD_RST_Q;
               q_ba[k]    <= 3'h0;
               q_ras[k]   <= 1'b0;
               q_cas[k]   <= 1'b0;
               q_we[k]    <= 1'b0;
               q_cs[k]    <= 2'h0;
               q_cke[k]   <= 2'h0;
               q_odt[k]   <= 2'h0;
               q_ca_oe[k] <= 1'b0;
               q_ct_oe[k] <= 1'b0;
            end else begin
               q_ct_oe[k] <= ~dis;
               if (use_valid) begin
                  q_cke[k] <= use_word[`RCD_F_CKE+1:`RCD_F_CKE];
                  q_odt[k] <= use_word[`RCD_F_ODT+1:`RCD_F_ODT];
                  q_cs[k]  <= cs_slice;
                  q_ca_oe[k] <= ~dis & (use_cls != `RCD_CLS_FLOAT);
                  if (use_cls == `RCD_CLS_FWD) begin
                     q_addr[k] <= use_word[`RCD_F_ADDR+15:`RCD_F_ADDR];
                     q_ba[k]   <= use_word[`RCD_F_BA+2:`RCD_F_BA];
                     q_ras[k]  <= use_word[`RCD_F_RAS];
                     q_cas[k]  <= use_word[`RCD_F_CAS];
                     q_we[k]   <= use_word[`RCD_F_WE];
                  end
               end else begin
                  q_ca_oe[k] <= ~dis & q_ca_oe[k] | ~dis & ~q_ct_oe[k];
               end
            end
         end
      end
   endgenerate

   assign O_ADDR_OUT_A             = q_addr[0];
   assign O_BANK_ADDR_OUT_A        = q_ba[0];
   assign O_ROW_STROBE_OUT_A       = q_ras[0];
   assign O_COLUMN_STROBE_OUT_A    = q_cas[0];
   assign O_WRITE_EN_OUT_A         = q_we[0];
   assign O_CHIP_SEL_OUT_A         = q_cs[0];
   assign O_DRAM_CLK_EN_OUT_A      = q_cke[0];
   assign O_TERMINATION_CTRL_OUT_A = q_odt[0];
   assign O_CMD_ADDR_OE_A          = q_ca_oe[0];
   assign O_CTRL_OE_A              = q_ct_oe[0];
   assign O_ADDR_OUT_B             = q_addr[1];
   assign O_BANK_ADDR_OUT_B        = q_ba[1];
   assign O_ROW_STROBE_OUT_B       = q_ras[1];
   assign O_COLUMN_STROBE_OUT_B    = q_cas[1];
   assign O_WRITE_EN_OUT_B         = q_we[1];
   assign O_CHIP_SEL_OUT_B         = q_cs[1];
   assign O_DRAM_CLK_EN_OUT_B      = q_cke[1];
   assign O_TERMINATION_CTRL_OUT_B = q_odt[1];
   assign O_CMD_ADDR_OE_B          = q_ca_oe[1];
   assign O_CTRL_OE_B              = q_ct_oe[1];

endmodule // rcd_main

`default_nettype wire

// ==== rcd_main_asserts.sv ====
// Concurrent checks on the command/address buffer, seen from its top ports only.
// Assumes a bind onto rcd_main; the bind statement follows the module.
`include "rcd_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module rcd_chk (
   input wire logic                  I_REF_CLK,
   input wire logic                  I_RST_B,
   input wire logic [1:0]            I_DRAM_CLK_EN_IN,
   input wire logic [15:0]           I_ADDR_IN,
   input wire logic [2:0]            I_BANK_ADDR_IN,
   input wire logic                  I_ROW_STROBE_IN,
   input wire logic                  I_COLUMN_STROBE_IN,
   input wire logic                  I_WRITE_EN_IN,
   input wire logic                  I_CHIP_SEL_IN_0,
   input wire logic                  I_CHIP_SEL_IN_1,
   input wire logic                  I_PARITY_BIT_IN,
   input wire logic [`RCD_CW0_W-1:0] I_CONTROL_WORD_ZERO,
   input wire logic                  I_DRAIN_EN,
   input wire logic [15:0]           O_ADDR_OUT_A,
   input wire logic [1:0]            O_CHIP_SEL_OUT_A,
   input wire logic [1:0]            O_DRAM_CLK_EN_OUT_A,
   input wire logic                  O_CMD_ADDR_OE_A,
   input wire logic                  O_CTRL_OE_A,
   input wire logic                  O_PARITY_FAIL_N,
   input wire logic                  O_FOUR_SELECT_MODE
);
   logic [2:0] run;
   logic       stall;
   wire        steady = (run >= 3'h5) && !stall;

   // A stalled buffer keeps its backlog for good, so latency checks stay off until the next reset.
   always @(posedge I_REF_CLK) begin
      if (!I_RST_B) begin
         run   <= 3'h0;
         stall <= 1'h0;
      end else begin
         if (!I_DRAIN_EN)
            stall <= 1'h1;
         if (I_CONTROL_WORD_ZERO[`RCD_CW0_LAT_3T])
            run <= 3'h0;
         else if (run != 3'h7)
            run <= run + 3'h1;
      end
   end

   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_B);

   sequence seq_err_low;
      !O_PARITY_FAIL_N ##1 !O_PARITY_FAIL_N;
   endsequence
   sequence seq_dis_a;
      I_CONTROL_WORD_ZERO[`RCD_CW0_DIS_A] [*2];
   endsequence

   chk_reset_quiet: assert property (disable iff (1'h0) !I_RST_B |=> O_PARITY_FAIL_N
      && !O_CTRL_OE_A && !O_CMD_ADDR_OE_A && O_ADDR_OUT_A == 16'h0000) else $error("outputs not quiet in reset");
   chk_err_two_low: assert property ($fell(O_PARITY_FAIL_N) |-> seq_err_low)
      else $error("error pulse shorter than two cycles");
   chk_err_on_odd: assert property (steady && $past(!I_CHIP_SEL_IN_0 || !I_CHIP_SEL_IN_1, 4)
      && $past(^{I_ADDR_IN, I_BANK_ADDR_IN, I_ROW_STROBE_IN, I_COLUMN_STROBE_IN, I_WRITE_EN_IN}, 4)
      != $past(I_PARITY_BIT_IN, 3) |-> seq_err_low) else $error("parity error not flagged on time");
   chk_ctrl_follow: assert property (steady && O_CTRL_OE_A |-> O_DRAM_CLK_EN_OUT_A == $past(I_DRAM_CLK_EN_IN, 2))
      else $error("clock enable not forwarded");
   chk_addr_forward: assert property (steady && !O_FOUR_SELECT_MODE && O_CMD_ADDR_OE_A
      && $past(I_CHIP_SEL_IN_0 ^ I_CHIP_SEL_IN_1, 2) |-> O_ADDR_OUT_A == $past(I_ADDR_IN, 2)
      && O_CHIP_SEL_OUT_A == $past({I_CHIP_SEL_IN_1, I_CHIP_SEL_IN_0}, 2)) else $error("selected word not forwarded");
   chk_both_hold: assert property (steady && $past(!I_CHIP_SEL_IN_0 && !I_CHIP_SEL_IN_1, 2)
      |-> $stable(O_ADDR_OUT_A) && O_CHIP_SEL_OUT_A == 2'h3) else $error("both selects low changed outputs");
   chk_upper_ignored: assert property (steady && !O_FOUR_SELECT_MODE
      && $past(I_CHIP_SEL_IN_0 && I_CHIP_SEL_IN_1 && !I_CONTROL_WORD_ZERO[`RCD_CW0_FLOAT], 2)
      |-> $stable(O_ADDR_OUT_A) && O_CHIP_SEL_OUT_A == 2'h3) else $error("unselected word changed outputs");
   chk_copy_a_off: assert property (seq_dis_a |=> !O_CTRL_OE_A && !O_CMD_ADDR_OE_A)
      else $error("disabled copy still driven");
endmodule // rcd_chk

bind rcd_main rcd_chk i_chk (.I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B), .I_DRAM_CLK_EN_IN(I_DRAM_CLK_EN_IN),
   .I_ADDR_IN(I_ADDR_IN), .I_BANK_ADDR_IN(I_BANK_ADDR_IN), .I_ROW_STROBE_IN(I_ROW_STROBE_IN),
   .I_COLUMN_STROBE_IN(I_COLUMN_STROBE_IN), .I_WRITE_EN_IN(I_WRITE_EN_IN), .I_CHIP_SEL_IN_0(I_CHIP_SEL_IN_0),
   .I_CHIP_SEL_IN_1(I_CHIP_SEL_IN_1), .I_PARITY_BIT_IN(I_PARITY_BIT_IN), .I_CONTROL_WORD_ZERO(I_CONTROL_WORD_ZERO),
   .I_DRAIN_EN(I_DRAIN_EN), .O_ADDR_OUT_A(O_ADDR_OUT_A), .O_CHIP_SEL_OUT_A(O_CHIP_SEL_OUT_A),
   .O_DRAM_CLK_EN_OUT_A(O_DRAM_CLK_EN_OUT_A), .O_CMD_ADDR_OE_A(O_CMD_ADDR_OE_A), .O_CTRL_OE_A(O_CTRL_OE_A),
   .O_PARITY_FAIL_N(O_PARITY_FAIL_N), .O_FOUR_SELECT_MODE(O_FOUR_SELECT_MODE));
`default_nettype wire

// ==== rcd_ctrl_model.sv ====
// Behavioural memory controller driving the buffer's command/address inputs.
// Assumes send is called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module rcd_ctrl_model (
   input  wire logic        i_clk,
   output logic      [15:0] o_addr,
   output logic      [2:0]  o_bank,
   output logic      [2:0]  o_cmd,
   output logic      [3:0]  o_cs,
   output logic             o_par,
   output logic      [1:0]  o_cke,
   output logic      [1:0]  o_odt
);
   initial begin
      o_addr = 16'h0000;
      o_bank = 3'h0;
      o_cmd  = 3'h7;
      o_cs   = 4'hF;
      o_par  = 1'h0;
      o_cke  = 2'h0;
      o_odt  = 2'h0;
   end

   // Released address, bank and command lines flip to their inverse and the selects go idle, so a stale bus is never mistaken for a held output.
   task automatic send(input logic [3:0] cs, input logic [15:0] a, input logic [2:0] ba, input logic [2:0] cmd,
                       input logic bad);
      o_cs   = cs;
      o_addr = a;
      o_bank = ba;
      o_cmd  = cmd;
      o_cke  = a[1:0];
      o_odt  = ~a[1:0];
      @(posedge i_clk);
      #1;
      o_par  = ^{a, ba, cmd} ^ bad;
      o_cs   = 4'hF;
      o_addr = ~a;
      o_bank = ~ba;
      o_cmd  = ~cmd;
      @(posedge i_clk);
      #1;
      o_par  = ~o_par;
   endtask
endmodule // rcd_ctrl_model
`default_nettype wire

// ==== rcd_main_tb_top.sv ====
// Self-checking bench for the command/address buffer: table of words, then hand-written cases.
// Assumes the controller model and the bound checker are compiled with the design.
`include "rcd_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module rcd_main_tb_top;
   typedef struct packed {
      logic [3:0] cs; logic [15:0] a; logic [2:0] ba; logic [2:0] cmd; logic bad; logic [1:0] exp_cs; logic exp_err;
   } rcd_row_t;
   rcd_row_t rows [7] = '{'{4'hE, 16'h1234, 3'h5, 3'h6, 1'h0, 2'h2, 1'h0}, '{4'hD, 16'hABCD, 3'h2, 3'h1, 1'h1, 2'h1, 1'h1},
      '{4'hC, 16'hFFFF, 3'h7, 3'h7, 1'h0, 2'h3, 1'h0}, '{4'h3, 16'h5A5A, 3'h1, 3'h2, 1'h1, 2'h3, 1'h0},
      '{4'hE, 16'hFFFF, 3'h7, 3'h7, 1'h0, 2'h2, 1'h0}, '{4'hE, 16'h0000, 3'h0, 3'h0, 1'h1, 2'h2, 1'h1},
      '{4'hF, 16'h0F0F, 3'h3, 3'h4, 1'h1, 2'h3, 1'h0}};
   logic                  clk, rst_b, flip, strap_n, drain;
   logic [`RCD_CW0_W-1:0] cw;
   logic [21:0]           prev;
   int                    failures = 0, n_checks = 0, cycles = 0;
   wire  [15:0]           d_addr, addr_a, addr_b;
   wire  [3:0]            d_cs;
   wire  [2:0]            d_ba, d_cmd, ba_a;
   wire  [1:0]            d_cke, d_odt, cs_a, cs_b, cke_a;
   wire                   d_par, ras_a, cas_a, we_a, oe_a, ctl_a, ctl_b, err_n, term, four, accept;

   rcd_ctrl_model i_ctrl (.i_clk(clk), .o_addr(d_addr), .o_bank(d_ba), .o_cmd(d_cmd), .o_cs(d_cs), .o_par(d_par),
      .o_cke(d_cke), .o_odt(d_odt));
   rcd_main i_dut (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_DRAM_CLK_EN_IN(d_cke), .I_TERMINATION_CTRL_IN(d_odt),
      .I_ADDR_IN(d_addr), .I_BANK_ADDR_IN(d_ba), .I_ROW_STROBE_IN(d_cmd[2]), .I_COLUMN_STROBE_IN(d_cmd[1]),
      .I_WRITE_EN_IN(d_cmd[0]), .I_CHIP_SEL_IN_0(d_cs[0]), .I_CHIP_SEL_IN_1(d_cs[1]), .I_CHIP_SEL_IN_2(d_cs[2]),
      .I_CHIP_SEL_IN_3(d_cs[3]), .I_PARITY_BIT_IN(d_par), .I_BALLOUT_FLIP(flip), .I_FOUR_SELECT_STRAP_N(strap_n),
      .I_CONTROL_WORD_ZERO(cw), .I_DRAIN_EN(drain), .O_ADDR_OUT_A(addr_a), .O_BANK_ADDR_OUT_A(ba_a),
      .O_ROW_STROBE_OUT_A(ras_a), .O_COLUMN_STROBE_OUT_A(cas_a), .O_WRITE_EN_OUT_A(we_a), .O_CHIP_SEL_OUT_A(cs_a),
      .O_DRAM_CLK_EN_OUT_A(cke_a), .O_TERMINATION_CTRL_OUT_A(), .O_CMD_ADDR_OE_A(oe_a), .O_CTRL_OE_A(ctl_a),
      .O_ADDR_OUT_B(addr_b), .O_BANK_ADDR_OUT_B(), .O_ROW_STROBE_OUT_B(), .O_COLUMN_STROBE_OUT_B(),
      .O_WRITE_EN_OUT_B(), .O_CHIP_SEL_OUT_B(cs_b), .O_DRAM_CLK_EN_OUT_B(), .O_TERMINATION_CTRL_OUT_B(),
      .O_CMD_ADDR_OE_B(), .O_CTRL_OE_B(ctl_b), .O_PARITY_FAIL_N(err_n), .O_PARITY_FAIL_OE(),
      .O_INPUT_LINE_TERMINATION(term), .O_FOUR_SELECT_MODE(four), .O_ACCEPT(accept));

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string name, input logic [21:0] seen, input logic [21:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic final_report;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic do_reset(input logic f, input logic s);
      rst_b = 1'h0;
      flip = f;
      strap_n = s;
      step(4);
      check("in_reset", {err_n, oe_a, ctl_a, accept, addr_a}, {4'h8, 16'h0000});
      rst_b = 1'h1;
      step(2);
      check("after_reset", {err_n, oe_a, ctl_a, addr_a}, {3'h7, 16'h0000});
      prev = 22'h00_0000;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         final_report;
      end
   end

   initial begin
      cw = 5'h00;
      drain = 1'h1;
      do_reset(1'h0, 1'h1);
      foreach (rows[i]) begin
         i_ctrl.send(rows[i].cs, rows[i].a, rows[i].ba, rows[i].cmd, rows[i].bad);
         if (rows[i].exp_cs != 2'h3)
            prev = {rows[i].a, rows[i].ba, rows[i].cmd};
         // The select outputs stand for one cycle only: the released bus follows right behind.
         check("gated_a", {addr_a, ba_a, ras_a, cas_a, we_a}, prev);
         check("addr_b", addr_b, prev[21:6]);
         check("sel_ab", {cs_a, cs_b}, {rows[i].exp_cs, rows[i].exp_cs});
         check("clk_en_a", cke_a, rows[i].a[1:0]);
         step(1);
         for (int k = 0; k < 3; k++) begin
            step(1);
            check("err_n", err_n, k == 2 || !rows[i].exp_err);
         end
      end
      // Three-cycle timing adds one stage, so the word is still absent one edge early.
      cw = 5'h08;
      step(2);
      i_ctrl.send(4'hE, 16'h2468, 3'h4, 3'h2, 1'h0);
      check("lat3_early", addr_a, prev[21:6]);
      step(1);
      check("lat3", addr_a, 16'h2468);
      cw = 5'h10;
      step(3);
      check("float_idle", {oe_a, ctl_a}, 2'h1);
      i_ctrl.send(4'hE, 16'h3C3C, 3'h1, 3'h6, 1'h0);
      check("float_fwd", {oe_a, addr_a}, {1'h1, 16'h3C3C});
      cw = 5'h00;
      step(3);
      i_ctrl.send(4'hE, 16'h0001, 3'h0, 3'h0, 1'h1);
      i_ctrl.send(4'hD, 16'h8000, 3'h0, 3'h0, 1'h1);
      for (int k = 0; k < 5; k++) begin
         check("err_b2b", err_n, k == 4);
         step(1);
      end
      cw = 5'h01;
      step(3);
      check("copy_a_off", {ctl_a, oe_a, ctl_b}, 3'h1);
      cw = 5'h00;
      drain = 1'h0;
      i_ctrl.send(4'hE, 16'h7777, 3'h2, 3'h5, 1'h0);
      step(20);
      check("full", {accept, addr_a}, {1'h0, 16'h8000});
      drain = 1'h1;
      step(30);
      check("drained", {accept, addr_a}, {1'h1, 16'h7777});
      do_reset(1'h1, 1'h0);
      check("straps", {four, term}, 2'h2);
      i_ctrl.send(4'hB, 16'hC1E7, 3'h3, 3'h5, 1'h0);
      check("quad_sel", {cs_a, cs_b, addr_a}, {4'hE, 16'hC1E7});
      final_report;
   end
endmodule // rcd_main_tb_top
`default_nettype wire
